/* swpm_pkg.sv */
// package: constants, carriers and helpers for the port merge configuration block
package swpm_pkg;

  // ------------------------------------------------------------
  // port layout
  // ------------------------------------------------------------
  localparam int NUM_PORTS = 6;
  localparam int NUM_PAIRS = 3;
  localparam int LANES_PER_PORT = 4;
  localparam logic [5:0] UPSTREAM_MAP = 6'h01;

  // link width encodings of the max link width field
  localparam logic [5:0] WIDTH_X4 = 6'h04;
  localparam logic [5:0] WIDTH_X8 = 6'h08;

  // lane number of a port's first lane inside its owner
  localparam logic [2:0] LANE_BASE_LO = 3'h0;
  localparam logic [2:0] LANE_BASE_HI = 3'h4;

  // ------------------------------------------------------------
  // apb register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_UR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_LCAP_BASE = 8'h10;
  localparam logic [7:0] ADDR_LCAP_LAST = 8'h24;
  localparam int STS_MERGE_LSB = 0;
  localparam int STS_EN_LSB = 8;
  localparam int STS_UP_LSB = 16;
  localparam int STS_SAMPLED_BIT = 24;
  localparam int MLW_LSB = 4;
  localparam int UR_CNT_W = 16;
  localparam logic [15:0] UR_CNT_ONE = 16'h0001;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [3:0] hotplug;
    logic link_up;
    logic port_reset_n;
  } swpm_port_out_s;

  localparam swpm_port_out_s PORT_OUT_NEGATED = '{hotplug: 4'h0, link_up: 1'b0,
                                                  port_reset_n: 1'b1};

  typedef struct packed {
    logic [3:0] hotplug_n;
    logic presence_n;
  } swpm_port_in_s;

  localparam swpm_port_in_s PORT_IN_IDLE = '{hotplug_n: 4'hf, presence_n: 1'b1};

  typedef struct packed {
    logic valid;
    logic write;
    logic [4:0] dev;
  } swpm_cfg_req_s;

  typedef struct packed {
    logic valid;
    logic ur;
  } swpm_cfg_rsp_s;

  typedef struct packed {
    logic [2:0] port;
    logic [2:0] base;
  } swpm_lane_map_s;

  // a port is gone only when it is the odd half of a merged pair
  function automatic logic port_enabled(input logic [2:0] merge, input int port);
    port_enabled = !(port[0] && merge[port / 2]);
  endfunction : port_enabled

endpackage : swpm_pkg

/* swpm_pair_gate.sv */
// module: output, input and lane steering for one even/odd port pair
`timescale 1ns/1ps

module swpm_pair_gate #(
  parameter int PAIR = 0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // merge state of this pair
  input wire logic merged,
  // even port
  input swpm_pkg::swpm_port_out_s core_out_even,
  output swpm_pkg::swpm_port_out_s pin_out_even,
  input swpm_pkg::swpm_port_in_s pin_in_even,
  output swpm_pkg::swpm_port_in_s core_in_even,
  // odd port
  input swpm_pkg::swpm_port_out_s core_out_odd,
  output swpm_pkg::swpm_port_out_s pin_out_odd,
  input swpm_pkg::swpm_port_in_s pin_in_odd,
  output swpm_pkg::swpm_port_in_s core_in_odd,
  // lanes
  output swpm_pkg::swpm_lane_map_s odd_lane_map,
  output logic [5:0] even_lane_width
);

  localparam logic [2:0] EVEN_PORT = 3'(2 * PAIR);
  localparam logic [2:0] ODD_PORT = 3'(2 * PAIR + 1);

  // ------------------------------------------------------------
  // port pins
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_even <= swpm_pkg::PORT_OUT_NEGATED;
      core_in_even <= swpm_pkg::PORT_IN_IDLE;
    end else begin
      pin_out_even <= core_out_even;
      core_in_even <= pin_in_even;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_odd <= swpm_pkg::PORT_OUT_NEGATED;
      core_in_odd <= swpm_pkg::PORT_IN_IDLE;
    end else if (merged) begin
      // R07: odd outputs negated
      pin_out_odd <= swpm_pkg::PORT_OUT_NEGATED;
      // R08: odd inputs ignored
      core_in_odd <= swpm_pkg::PORT_IN_IDLE;
    end else begin
      // R04: independent x4 port
      pin_out_odd <= core_out_odd;
      core_in_odd <= pin_in_odd;
    end
  end

  // ------------------------------------------------------------
  // lanes
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      odd_lane_map <= '{port: ODD_PORT, base: swpm_pkg::LANE_BASE_LO};
      even_lane_width <= swpm_pkg::WIDTH_X4;
    end else if (merged) begin
      // R11 R14: odd lanes become even lanes four to seven
      odd_lane_map <= '{port: EVEN_PORT, base: swpm_pkg::LANE_BASE_HI};
      even_lane_width <= swpm_pkg::WIDTH_X8;
    end else begin
      odd_lane_map <= '{port: ODD_PORT, base: swpm_pkg::LANE_BASE_LO};
      even_lane_width <= swpm_pkg::WIDTH_X4;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_odd_out_negated;
    merged ##1 merged |-> pin_out_odd == swpm_pkg::PORT_OUT_NEGATED;
  endproperty
  a_odd_out_negated: assert property (p_odd_out_negated) // R07
    else $error("odd port output not negated while merged");

  property p_odd_in_ignored;
    merged ##1 merged |-> core_in_odd == swpm_pkg::PORT_IN_IDLE;
  endproperty
  a_odd_in_ignored: assert property (p_odd_in_ignored) // R08
    else $error("odd port input reached core while merged");

  property p_unmerged_pass;
    // flops still sit in reset at the release edge, so that edge starts no check
    presetn && !merged |=> pin_out_odd == $past(core_out_odd)
                           && core_in_odd == $past(pin_in_odd);
  endproperty
  a_unmerged_pass: assert property (p_unmerged_pass) // R04
    else $error("unmerged odd port not passed through");

  property p_lane_map;
    merged |=> odd_lane_map.port == EVEN_PORT && odd_lane_map.base == swpm_pkg::LANE_BASE_HI
               && even_lane_width == swpm_pkg::WIDTH_X8;
  endproperty
  a_lane_map: assert property (p_lane_map) // R14
    else $error("odd lanes not steered to even port lanes four to seven");

endmodule : swpm_pair_gate

/* swpm_merge_cfg.sv */
// module: top of the port merge configuration block with its apb register slave
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps

// Behaviour
// R01: six ports zero to five, each four lanes wide when unmerged.
// R02: port zero is always upstream, ports one to five always downstream.
// R03: only an even port and the next odd port merge, as the even port.
// R04: with the strap released both ports of the pair run as x4 ports.
// R05: merge is fixed at fundamental reset, exactly when the pair strap is asserted.
// R06: a merged pair disables the odd port, its bridge and its resources.
// R07: all outputs of a disabled odd port stay negated.
// R08: all inputs of a disabled odd port are ignored.
// R09: configuration access to a disabled odd device completes as unsupported request.
// R10: registers of a disabled odd port are unreachable; masters must not address them.
// R11: odd lanes are run by the even port as its own, giving eight lanes.
// R12: merged even port's max link width field resets to x8.
// R13: straps are active low; low merges, high keeps two x4 ports.
// R14: merged odd lanes become lanes four to seven of the even port.
// R15: straps sampled at fundamental reset release; later changes have no effect.
module swpm_merge_cfg (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // boot straps
  input wire logic fundamental_reset_n,
  input wire logic pair01_merge_n,
  input wire logic pair23_merge_n,
  input wire logic pair45_merge_n,
  // port configuration
  output logic [5:0] port_enable,
  output logic [5:0] port_upstream,
  output logic [5:0] max_link_width_field [6],
  output logic [5:0] even_lane_width [3],
  output swpm_pkg::swpm_lane_map_s odd_lane_map [3],
  // port side signals
  input swpm_pkg::swpm_port_out_s core_out [6],
  output swpm_pkg::swpm_port_out_s pin_out [6],
  input swpm_pkg::swpm_port_in_s pin_in [6],
  output swpm_pkg::swpm_port_in_s core_in [6],
  // configuration requests on the virtual bus
  input swpm_pkg::swpm_cfg_req_s cfg_req,
  output swpm_pkg::swpm_cfg_rsp_s cfg_rsp
);

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function automatic logic lcap_hit(input logic [7:0] addr);
    lcap_hit = addr >= swpm_pkg::ADDR_LCAP_BASE && addr <= swpm_pkg::ADDR_LCAP_LAST
               && addr[1:0] == 2'h0;
  endfunction : lcap_hit

  function automatic logic [2:0] lcap_port(input logic [7:0] addr);
    logic [7:0] off;
    off = addr - swpm_pkg::ADDR_LCAP_BASE;
    lcap_port = off[4:2];
  endfunction : lcap_port

  function automatic logic dev_exists(input logic [2:0] merge, input logic [4:0] dev);
    dev_exists = dev < 5'(swpm_pkg::NUM_PORTS) && swpm_pkg::port_enabled(merge, int'(dev));
  endfunction : dev_exists

  // ------------------------------------------------------------
  // strap sampling
  // ------------------------------------------------------------
  logic [2:0] straps_n;
  logic fr_q;
  logic fr_rel;
  logic [2:0] merge_q;
  logic sampled_q;

  assign straps_n = {pair45_merge_n, pair23_merge_n, pair01_merge_n};
  assign fr_rel = fundamental_reset_n && !fr_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fr_q <= 1'b0;
    end else begin
      fr_q <= fundamental_reset_n;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      merge_q <= 3'h0;
      sampled_q <= 1'b0;
    end else if (fr_rel) begin
      // R05 R13 R15: active low straps caught at reset release only
      merge_q <= ~straps_n;
      sampled_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // port roles
  // ------------------------------------------------------------
  logic [5:0] en_vec;

  always_comb begin
    en_vec = '0;
    for (int p = 0; p < swpm_pkg::NUM_PORTS; p++) begin
      // R03 R06: odd half of a merged pair drops out
      en_vec[p] = swpm_pkg::port_enabled(merge_q, p);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_enable <= 6'h3f;
      port_upstream <= swpm_pkg::UPSTREAM_MAP;
    end else begin
      port_enable <= en_vec;
      // R02: roles never follow the merge setting
      port_upstream <= swpm_pkg::UPSTREAM_MAP;
    end
  end

  // ------------------------------------------------------------
  // pair steering
  // ------------------------------------------------------------
  for (genvar g = 0; g < swpm_pkg::NUM_PAIRS; g++) begin : g_pair
    swpm_pair_gate #(.PAIR(g)) u_gate (
      .pclk(pclk),
      .presetn(presetn),
      .merged(merge_q[g]),
      .core_out_even(core_out[2 * g]),
      .pin_out_even(pin_out[2 * g]),
      .pin_in_even(pin_in[2 * g]),
      .core_in_even(core_in[2 * g]),
      .core_out_odd(core_out[2 * g + 1]),
      .pin_out_odd(pin_out[2 * g + 1]),
      .pin_in_odd(pin_in[2 * g + 1]),
      .core_in_odd(core_in[2 * g + 1]),
      .odd_lane_map(odd_lane_map[g]),
      .even_lane_width(even_lane_width[g])
    );
  end

  // ------------------------------------------------------------
  // link capability width fields
  // ------------------------------------------------------------
  logic apb_wr;
  logic apb_setup;
  logic acc_err;
  logic [2:0] wr_port;

  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite;
  assign wr_port = lcap_port(paddr);

  for (genvar p = 0; p < swpm_pkg::NUM_PORTS; p++) begin : g_lcap
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        max_link_width_field[p] <= swpm_pkg::WIDTH_X4;
      end else if (fr_rel) begin
        // R12: merged even port starts at x8, all others at x4
        if (p % 2 == 0 && !straps_n[p / 2]) begin
          max_link_width_field[p] <= swpm_pkg::WIDTH_X8;
        end else begin
          // R01: unmerged port is four lanes
          max_link_width_field[p] <= swpm_pkg::WIDTH_X4;
        end
      end else if (apb_wr && lcap_hit(paddr) && wr_port == 3'(p) && en_vec[p]) begin
        max_link_width_field[p] <= pwdata[swpm_pkg::MLW_LSB +: 6];
      end
    end
  end

  // ------------------------------------------------------------
  // configuration requests
  // ------------------------------------------------------------
  logic [15:0] ur_cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_rsp <= '0;
    end else begin
      cfg_rsp.valid <= cfg_req.valid;
      // R09: removed device answers unsupported request
      cfg_rsp.ur <= cfg_req.valid && !dev_exists(merge_q, cfg_req.dev);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ur_cnt_q <= '0;
    end else if (cfg_req.valid && !dev_exists(merge_q, cfg_req.dev)) begin
      ur_cnt_q <= ur_cnt_q + swpm_pkg::UR_CNT_ONE;
    end
  end

  // ------------------------------------------------------------
  // apb read path
  // ------------------------------------------------------------
  logic [31:0] rd_data;
  logic rd_err;

  // data is latched in the setup cycle so prdata comes from a flop
  always_comb begin
    rd_data = '0;
    rd_err = 1'b0;
    if (paddr == swpm_pkg::ADDR_STATUS) begin
      rd_data[swpm_pkg::STS_MERGE_LSB +: 3] = merge_q;
      rd_data[swpm_pkg::STS_EN_LSB +: 6] = en_vec;
      rd_data[swpm_pkg::STS_UP_LSB +: 6] = swpm_pkg::UPSTREAM_MAP;
      rd_data[swpm_pkg::STS_SAMPLED_BIT] = sampled_q;
    end else if (paddr == swpm_pkg::ADDR_UR_COUNT) begin
      rd_data[swpm_pkg::UR_CNT_W - 1:0] = ur_cnt_q;
    end else if (lcap_hit(paddr)) begin
      // R10: removed port's register is cut off
      if (en_vec[wr_port]) begin
        rd_data[swpm_pkg::MLW_LSB +: 6] = max_link_width_field[wr_port];
      end else begin
        rd_err = 1'b1;
      end
    end else begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      acc_err <= 1'b0;
    end else if (apb_setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_data;
      acc_err <= rd_err;
    end
  end

  // zero wait states: the access phase always completes at once
  assign pready = 1'b1;
  assign pslverr = psel && penable && acc_err;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_upstream_fixed;
    ##1 port_upstream == swpm_pkg::UPSTREAM_MAP;
  endproperty
  a_upstream_fixed: assert property (p_upstream_fixed) // R02
    else $error("upstream port map changed");

  property p_strap_sample;
    fr_rel |=> merge_q == ~$past(straps_n) && sampled_q;
  endproperty
  a_strap_sample: assert property (p_strap_sample) // R05
    else $error("merge state does not match straps at release");

  property p_strap_hold;
    !fr_rel |=> $stable(merge_q);
  endproperty
  a_strap_hold: assert property (p_strap_hold) // R15
    else $error("merge state changed outside reset release");

  property p_odd_disabled;
    merge_q[1] ##1 merge_q[1] |-> !port_enable[3] && port_enable[2];
  endproperty
  a_odd_disabled: assert property (p_odd_disabled) // R06
    else $error("merged pair enable pattern wrong");

  property p_cfg_ur;
    cfg_req.valid && cfg_req.dev[0] && cfg_req.dev < 5'(swpm_pkg::NUM_PORTS)
      && merge_q[cfg_req.dev[2:1]]
      |=> cfg_rsp.valid && cfg_rsp.ur;
  endproperty
  a_cfg_ur: assert property (p_cfg_ur) // R09
    else $error("removed device did not answer unsupported request");

  property p_mlw_x8;
    fr_rel && !straps_n[1] |=> max_link_width_field[2] == swpm_pkg::WIDTH_X8
                               && en_vec[3] == 1'b0;
  endproperty
  a_mlw_x8: assert property (p_mlw_x8) // R12
    else $error("merged even port width field not x8");

  property p_mlw_x4;
    fr_rel && straps_n[2] |=> max_link_width_field[4] == swpm_pkg::WIDTH_X4
                              && max_link_width_field[5] == swpm_pkg::WIDTH_X4;
  endproperty
  a_mlw_x4: assert property (p_mlw_x4) // R01
    else $error("unmerged port width field not x4");

  property p_apb_removed;
    psel && !penable && !pwrite && lcap_hit(paddr) && !en_vec[lcap_port(paddr)]
      ##1 psel && penable |-> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_apb_removed: assert property (p_apb_removed) // R10
    else $error("removed port register answered normally");

  c_all_merged: cover property (fr_rel && straps_n == 3'h0);
  c_none_merged: cover property (fr_rel && straps_n == 3'h7);
  c_ur_seen: cover property (cfg_rsp.valid && cfg_rsp.ur);

endmodule : swpm_merge_cfg

/* swpm_link_model.sv */
// link model: root config requests and link partner pin activity
`timescale 1ns/1ps

module swpm_link_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // commands from the bench
  input wire logic req_go,
  input wire logic req_wr,
  input wire logic [4:0] req_dev,
  // virtual bus towards the switch
  output swpm_pkg::swpm_cfg_req_s cfg_req,
  input swpm_pkg::swpm_cfg_rsp_s cfg_rsp,
  output logic rsp_seen,
  output logic rsp_ur,
  // link partner pins
  output swpm_pkg::swpm_port_in_s pin_in [6],
  output swpm_pkg::swpm_port_in_s prev_in [6]
);
  logic [7:0] cnt_q = 8'h00;
  logic [7:0] prv_q = 8'hff;

  // ------------------------------------------------------------
  // pin activity
  // ------------------------------------------------------------
  // the pin pattern changes every cycle so an input that leaks through shows up
  always @(posedge pclk) begin
    cnt_q <= cnt_q + 8'h01;
    prv_q <= cnt_q;
  end

  always_comb begin
    for (int p = 0; p < 6; p++) begin
      pin_in[p] = {cnt_q[3:0] ^ 4'(p), cnt_q[4] ^ cnt_q[0]};
      prev_in[p] = {prv_q[3:0] ^ 4'(p), prv_q[4] ^ prv_q[0]};
    end
  end

  // ------------------------------------------------------------
  // root side requests
  // ------------------------------------------------------------
  // no register side access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_req <= '0;
      rsp_seen <= 1'b0;
      rsp_ur <= 1'b0;
    end else begin
      cfg_req <= '{valid: req_go, write: req_wr, dev: req_dev};
      rsp_seen <= cfg_rsp.valid;
      rsp_ur <= cfg_rsp.ur;
    end
  end
endmodule : swpm_link_model

/* testbench.sv */
// testbench: strap rows, pin gating, config requests and apb checks
`timescale 1ns/1ps

module testbench;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic fundamental_reset_n;
  logic [2:0] strap_n;
  logic [5:0] port_enable, port_upstream;
  logic [5:0] max_link_width_field [6];
  logic [5:0] even_lane_width [3];
  swpm_pkg::swpm_lane_map_s odd_lane_map [3];
  swpm_pkg::swpm_port_out_s core_out [6];
  swpm_pkg::swpm_port_out_s pin_out [6];
  swpm_pkg::swpm_port_in_s pin_in [6];
  swpm_pkg::swpm_port_in_s prev_in [6];
  swpm_pkg::swpm_port_in_s core_in [6];
  swpm_pkg::swpm_cfg_req_s cfg_req;
  swpm_pkg::swpm_cfg_rsp_s cfg_rsp;
  logic req_go, req_wr, rsp_seen, rsp_ur;
  logic [4:0] req_dev;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  localparam swpm_pkg::swpm_port_out_s ACT_OUT = '{hotplug: 4'ha, link_up: 1'b1,
                                                   port_reset_n: 1'b0};
  typedef struct packed {
    logic [2:0] strap_n;
    logic [2:0] merge;
  } swpm_row_s;
  swpm_row_s rows [6] = '{'{3'h7, 3'h0}, '{3'h6, 3'h1}, '{3'h5, 3'h2}, '{3'h3, 3'h4},
                          '{3'h2, 3'h5}, '{3'h0, 3'h7}};

  swpm_merge_cfg dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fundamental_reset_n(fundamental_reset_n),
    .pair01_merge_n(strap_n[0]), .pair23_merge_n(strap_n[1]), .pair45_merge_n(strap_n[2]),
    .port_enable(port_enable), .port_upstream(port_upstream),
    .max_link_width_field(max_link_width_field), .even_lane_width(even_lane_width),
    .odd_lane_map(odd_lane_map), .core_out(core_out), .pin_out(pin_out), .pin_in(pin_in),
    .core_in(core_in), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp));

  swpm_link_model link_u (.pclk(pclk), .presetn(presetn), .req_go(req_go), .req_wr(req_wr),
    .req_dev(req_dev), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .rsp_seen(rsp_seen),
    .rsp_ur(rsp_ur), .pin_in(pin_in), .prev_in(prev_in));

  // ------------------------------------------------------------
  // clock, timeout and helpers
  // ------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp32

  task automatic cmp6(input logic [5:0] got, input logic [5:0] exp);
    cmp32({26'h0, got}, {26'h0, exp});
  endtask : cmp6

  // single transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench timeout ends a wait that never completes
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cfg(input logic [4:0] dev, input logic exp_ur);
    int n;
    @(posedge pclk);
    req_go <= 1'b1;
    req_dev <= dev;
    req_wr <= dev[0];
    @(posedge pclk);
    req_go <= 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp_seen !== 1'b1 && n < 10);
    cmp6({5'h0, rsp_seen}, 6'h01);
    cmp6({5'h0, rsp_ur}, {5'h0, exp_ur});
  endtask : cfg

  task automatic boot(input logic [2:0] s_n);
    @(posedge pclk);
    fundamental_reset_n <= 1'b0;
    strap_n <= s_n;
    repeat (3) @(posedge pclk);
    fundamental_reset_n <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask : boot

  task automatic check_all(input logic [2:0] m);
    logic [5:0] en_v;
    logic [5:0] w_v [6];
    @(negedge pclk);
    for (int p = 0; p < 6; p++) begin
      en_v[p] = !(p[0] && m[p / 2]);
      w_v[p] = (!p[0] && m[p / 2]) ? swpm_pkg::WIDTH_X8 : swpm_pkg::WIDTH_X4;
      cmp6({5'h0, port_enable[p]}, {5'h0, en_v[p]});
      if (en_v[p]) cmp6(max_link_width_field[p], w_v[p]);
      cmp6(pin_out[p], en_v[p] ? ACT_OUT : swpm_pkg::PORT_OUT_NEGATED);
      cmp6({1'b0, core_in[p]}, {1'b0, en_v[p] ? prev_in[p] : swpm_pkg::PORT_IN_IDLE});
    end
    for (int g = 0; g < 3; g++) begin
      cmp6(even_lane_width[g], m[g] ? swpm_pkg::WIDTH_X8 : swpm_pkg::WIDTH_X4);
      cmp6(odd_lane_map[g], m[g] ? {3'(2 * g), swpm_pkg::LANE_BASE_HI} :
                                   {3'(2 * g + 1), swpm_pkg::LANE_BASE_LO});
    end
    cmp6(port_upstream, swpm_pkg::UPSTREAM_MAP);
    apb(1'b0, swpm_pkg::ADDR_STATUS, 32'h0, rd, err);
    cmp32(rd, {7'h0, 1'b1, 2'h0, swpm_pkg::UPSTREAM_MAP, 2'h0, en_v, 5'h0, m});
    for (int p = 0; p < 6; p++) begin
      apb(1'b0, swpm_pkg::ADDR_LCAP_BASE + 8'(4 * p), 32'h0, rd, err);
      cmp6({5'h0, err}, {5'h0, !en_v[p]});
      if (en_v[p]) cmp6(rd[swpm_pkg::MLW_LSB +: 6], w_v[p]);
      else cmp32(rd, 32'h0);
    end
    for (int d = 0; d < 7; d++) cfg(5'(d), d == 6 || (d[0] && m[d / 2]));
  endtask : check_all

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fundamental_reset_n = 1'b0;
    strap_n = 3'h7;
    req_go = 1'b0;
    req_wr = 1'b0;
    req_dev = 5'h00;
    for (int p = 0; p < 6; p++) core_out[p] = ACT_OUT;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      boot(rows[i].strap_n);
      check_all(rows[i].merge);
    end
    // straps move with no reset: nothing may change
    @(posedge pclk);
    strap_n <= 3'h7;
    repeat (4) @(posedge pclk);
    check_all(3'h7);
    // software override, then reload at the next boot
    apb(1'b1, swpm_pkg::ADDR_LCAP_BASE,
        {26'h0, swpm_pkg::WIDTH_X4} << swpm_pkg::MLW_LSB, rd, err);
    apb(1'b0, swpm_pkg::ADDR_LCAP_BASE, 32'h0, rd, err);
    cmp6(rd[swpm_pkg::MLW_LSB +: 6], swpm_pkg::WIDTH_X4);
    boot(3'h0);
    apb(1'b1, swpm_pkg::ADDR_STATUS, 32'hffffffff, rd, err);
    cmp32({31'h0, err}, 32'h0);
    check_all(3'h7);
    apb(1'b0, 8'h80, 32'h0, rd, err);
    cmp32({31'h0, err}, 32'h1);
    apb(1'b0, swpm_pkg::ADDR_LCAP_BASE + 8'h02, 32'h0, rd, err);
    cmp32({31'h0, err}, 32'h1);
    // second reset in mid-run
    @(posedge pclk);
    presetn <= 1'b0;
    fundamental_reset_n <= 1'b0;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    cmp6(port_enable, 6'h3f);
    cmp6(max_link_width_field[0], swpm_pkg::WIDTH_X4);
    @(posedge pclk);
    presetn <= 1'b1;
    boot(3'h7);
    cfg(5'h06, 1'b1);
    cfg(5'h1f, 1'b1);
    cfg(5'h01, 1'b0);
    apb(1'b0, swpm_pkg::ADDR_UR_COUNT, 32'h0, rd, err);
    cmp32(rd, 32'h2);
    finish_test();
  end
endmodule : testbench
